// ---- pcm_params.svh ----
`ifndef PCM_PARAMS_SVH
`define PCM_PARAMS_SVH
// register byte addresses
`define PCM_ADDR_POW_KEY1 32'hFFFF0404
`define PCM_ADDR_POW_CTL0 32'hFFFF0408
`define PCM_ADDR_POW_KEY2 32'hFFFF040C
`define PCM_ADDR_PLL_KEY1 32'hFFFF0410
`define PCM_ADDR_PLL_CTL 32'hFFFF0414
`define PCM_ADDR_PLL_KEY2 32'hFFFF0418
`define PCM_ADDR_POW_KEY3 32'hFFFF0434
`define PCM_ADDR_POW_CTL1 32'hFFFF0438
`define PCM_ADDR_POW_KEY4 32'hFFFF043C
`define PCM_ADDR_IRQ_STAT 32'hFFFF0480
`define PCM_ADDR_IRQ_MASK 32'hFFFF0484
`define PCM_ADDR_RST_CAUSE 32'hFFFF0488
`define PCM_ADDR_STATUS 32'hFFFF048C
// key values
`define PCM_KEY_PLL_FIRST 16'h00AA
`define PCM_KEY_PLL_SECOND 16'h0055
`define PCM_KEY_POW0_FIRST 16'h0001
`define PCM_KEY_POW0_SECOND 16'h00F4
`define PCM_KEY_POW1_FIRST 16'h0076
`define PCM_KEY_POW1_SECOND 16'h00B1
// reset values and writable bits
`define PCM_RST_PLL_CTL 16'h0021
`define PCM_RST_POW_CTL0 16'h0003
`define PCM_RST_POW_CTL1 16'h0004
`define PCM_MASK_PLL_CTL 16'h0023
`define PCM_MASK_POW_CTL0 16'h0077
`define PCM_MASK_POW_CTL1 16'h01FF
// field positions
`define PCM_DIV_LSB 0
`define PCM_DIV_MSB 2
`define PCM_MODE_LSB 4
`define PCM_MODE_MSB 6
`define PCM_REFSEL_BIT 5
`define PCM_CLKMODE_LSB 0
`define PCM_CLKMODE_MSB 1
`define PCM_POW1_MSB 8
`define PCM_CLKMODE_EXT 2'h3
// interrupt and status bits
`define PCM_IRQ_UNLOCK 0
`define PCM_IRQ_WAKE 1
`define PCM_ST_LOCK 0
`define PCM_ST_CORE_RUN 1
`define PCM_ST_LOW_POWER 2
// pll multiplier
`define PCM_PLL_MULT 11'h4FB
// timing, in ns, and conversion to cycles rounding up
`define PCM_CLK_PERIOD_NS 10
`define PCM_PAUSE_WAKE_NS 230
`define PCM_NAP_WAKE_NS 283
`define PCM_SLOW_WAKE_NS 3000
`define PCM_SLEEP_WAKE_NS 1230000
`define PCM_STOP_WAKE_NS 1450000
`define PCM_NS_TO_CYC(ns) (((ns) + `PCM_CLK_PERIOD_NS - 1) / `PCM_CLK_PERIOD_NS)
`endif

// ---- pcm_pkg.sv ----
package pcm_pkg;
  // operating modes as held in the mode field
  typedef enum logic [2:0] {
    MODE_ACTIVE = 3'h0,
    MODE_PAUSE = 3'h1,
    MODE_NAP = 3'h2,
    MODE_SLEEP = 3'h3,
    MODE_STOP = 3'h4
  } pcm_mode_t;
  // power sequencer states, gray along active-low-wake
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'h0,
    ST_LOW = 2'h1,
    ST_WAKE = 2'h3
  } pcm_fsm_t;
  // key sequence progress
  typedef enum logic [1:0] {
    KS_IDLE = 2'h0,
    KS_KEYED = 2'h1,
    KS_LOADED = 2'h3
  } pcm_key_t;
endpackage : pcm_pkg

// ---- pcm_core_clock_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcm_core_clock_gen #(
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic [2:0] core_clock_divider,
  input wire logic use_ext,
  input wire logic run,
  // external clock pin
  input wire logic external_clock_input,
  // core clock enable
  output logic core_clock_tick
);
  localparam logic [CNT_W-1:0] ONE = CNT_W'(1);
  // previous pin level for edge detection
  logic ext_q;
  // divider count
  logic [CNT_W-1:0] cnt;
  // terminal count, two to the power of the divider, minus one
  logic [CNT_W-1:0] limit;

  assign limit = (ONE << core_clock_divider) - ONE;

  // pin history
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ext_q <= 1'b0;
    else
      ext_q <= external_clock_input;
  end

  // divider and tick
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= '0;
      core_clock_tick <= 1'b0;
    end
    else if (!run)
    begin
      // halted core sees no ticks
      cnt <= '0;
      core_clock_tick <= 1'b0;
    end
    else if (use_ext)
    begin
      // one tick per rising pin edge
      cnt <= '0;
      core_clock_tick <= external_clock_input && !ext_q;
    end
    else if (cnt >= limit)
    begin
      // tick once every 2^divider cycles
      cnt <= '0;
      core_clock_tick <= 1'b1;
    end
    else
    begin
      cnt <= cnt + ONE;
      core_clock_tick <= 1'b0;
    end
  end
endmodule : pcm_core_clock_gen
`default_nettype wire

// ---- pcm_top.sv ----
// Contract
// - pll locks at 1275 times reference
// - core clock is pll clock over 2^divider
// - divider resets to three
// - core clock may come from external pin
// - source select in pll control, internal default
// - lock loss halts core, interrupt after relock
// - record whether watchdog caused last reset
// - pause stops core only
// - nap stops core and peripherals
// - sleep drops pll, stop keeps only irqs
// - three control registers split the settings
// - protected registers change only by key sequence; hardware also clears the power zero mode field on wake
// - pll: 0xAA, value, 0x55 in order
// - power zero: 0x01, value, 0xF4 in order
// - mode codes; sleep/stop woken by irq0-3
//
// Decided for this implementation: strobed register access.
`include "pcm_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pcm_top #(
  parameter int WAKE_CNT_W = 18,
  parameter int SLEEP_WAKE_CYCLES = `PCM_NS_TO_CYC(`PCM_SLEEP_WAKE_NS),
  parameter int STOP_WAKE_CYCLES = `PCM_NS_TO_CYC(`PCM_STOP_WAKE_NS)
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [31:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // pll side
  input wire logic pll_locked,
  output logic pll_power_en,
  output logic pll_ref_internal,
  output logic [10:0] pll_mult_ratio,
  // clock domains
  input wire logic external_clock_input,
  output logic core_clock_tick,
  output logic core_clk_run,
  output logic periph_clk_run,
  output logic xtal_timer_en,
  output logic [2:0] core_clock_divider,
  output logic [8:0] serial_clock_config,
  // wake and reset cause
  input wire logic [3:0] ext_wake_irq,
  input wire logic periph_irq,
  input wire logic wdt_reset_cause,
  // interrupt
  output logic irq
);
  localparam logic [WAKE_CNT_W-1:0] CYC_PAUSE_FAST = WAKE_CNT_W'(`PCM_NS_TO_CYC(`PCM_PAUSE_WAKE_NS));
  localparam logic [WAKE_CNT_W-1:0] CYC_NAP_FAST = WAKE_CNT_W'(`PCM_NS_TO_CYC(`PCM_NAP_WAKE_NS));
  localparam logic [WAKE_CNT_W-1:0] CYC_SLOW = WAKE_CNT_W'(`PCM_NS_TO_CYC(`PCM_SLOW_WAKE_NS));
  localparam logic [WAKE_CNT_W-1:0] CYC_SLEEP = WAKE_CNT_W'(SLEEP_WAKE_CYCLES);
  localparam logic [WAKE_CNT_W-1:0] CYC_STOP = WAKE_CNT_W'(STOP_WAKE_CYCLES);
  localparam logic [WAKE_CNT_W-1:0] CNT_ONE = WAKE_CNT_W'(1);

  // protected control registers
  logic [15:0] pll_control_reg;
  logic [15:0] core_power_control_reg;
  logic [15:0] serial_clock_control_reg;
  // values held between the value write and the second key
  logic [15:0] pll_pending;
  logic [15:0] pow0_pending;
  logic [15:0] pow1_pending;
  // key sequence states
  pcm_pkg::pcm_key_t pll_ks;
  pcm_pkg::pcm_key_t pow0_ks;
  pcm_pkg::pcm_key_t pow1_ks;
  // commit strobes
  logic pll_commit;
  logic pow0_commit;
  logic pow1_commit;
  // sticky events, mask, reset cause
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [1:0] irq_set;
  logic reset_cause_status;
  logic cause_taken;
  // sequencer
  pcm_pkg::pcm_fsm_t fsm;
  pcm_pkg::pcm_fsm_t next_fsm;
  pcm_pkg::pcm_mode_t low_mode;
  pcm_pkg::pcm_mode_t req_mode;
  logic [WAKE_CNT_W-1:0] wake_cnt;
  logic [WAKE_CNT_W-1:0] wake_load;
  logic wake_event;
  logic wake_done;
  logic use_ext;
  logic pll_locked_q;
  logic unlock_event;

  // step a key sequence on one bus write
  function automatic pcm_pkg::pcm_key_t key_step(
    input pcm_pkg::pcm_key_t st,
    input logic [31:0] addr,
    input logic [15:0] data,
    input logic [31:0] a_key1,
    input logic [15:0] v_key1,
    input logic [31:0] a_reg
  );
    logic key1_hit;
    key1_hit = (addr == a_key1) && (data == v_key1);
    key_step = pcm_pkg::KS_IDLE;
    unique case (st)
      // only the right first key arms
      pcm_pkg::KS_IDLE: key_step = key1_hit ? pcm_pkg::KS_KEYED : pcm_pkg::KS_IDLE;
      // the value must follow at once
      pcm_pkg::KS_KEYED:
      begin
        if (addr == a_reg)
          key_step = pcm_pkg::KS_LOADED;
        else if (key1_hit)
          key_step = pcm_pkg::KS_KEYED;
      end
      // second key, right or wrong, ends the sequence
      pcm_pkg::KS_LOADED: key_step = key1_hit ? pcm_pkg::KS_KEYED : pcm_pkg::KS_IDLE;
      default: key_step = pcm_pkg::KS_IDLE;
    endcase
  endfunction : key_step

  // second key matches while a value is held
  function automatic logic key_done(
    input pcm_pkg::pcm_key_t st,
    input logic [31:0] addr,
    input logic [15:0] data,
    input logic [31:0] a_key2,
    input logic [15:0] v_key2
  );
    key_done = (st == pcm_pkg::KS_LOADED) && (addr == a_key2) && (data == v_key2);
  endfunction : key_done

  // commit decode
  assign pll_commit = reg_wr && key_done(pll_ks, reg_addr, reg_wdata, `PCM_ADDR_PLL_KEY2, `PCM_KEY_PLL_SECOND);
  assign pow0_commit = reg_wr && key_done(pow0_ks, reg_addr, reg_wdata, `PCM_ADDR_POW_KEY2, `PCM_KEY_POW0_SECOND);
  assign pow1_commit = reg_wr && key_done(pow1_ks, reg_addr, reg_wdata, `PCM_ADDR_POW_KEY4, `PCM_KEY_POW1_SECOND);

  // key sequence states move on writes only; reads leave them alone
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pll_ks <= pcm_pkg::KS_IDLE;
      pow0_ks <= pcm_pkg::KS_IDLE;
      pow1_ks <= pcm_pkg::KS_IDLE;
    end
    else if (reg_wr)
    begin
      pll_ks <= key_step(pll_ks, reg_addr, reg_wdata, `PCM_ADDR_PLL_KEY1, `PCM_KEY_PLL_FIRST,
                         `PCM_ADDR_PLL_CTL);
      pow0_ks <= key_step(pow0_ks, reg_addr, reg_wdata, `PCM_ADDR_POW_KEY1, `PCM_KEY_POW0_FIRST,
                          `PCM_ADDR_POW_CTL0);
      pow1_ks <= key_step(pow1_ks, reg_addr, reg_wdata, `PCM_ADDR_POW_KEY3, `PCM_KEY_POW1_FIRST,
                          `PCM_ADDR_POW_CTL1);
    end
  end

  // held values, captured only right after a good first key
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pll_pending <= 16'h0000;
      pow0_pending <= 16'h0000;
      pow1_pending <= 16'h0000;
    end
    else if (reg_wr)
    begin
      if (pll_ks == pcm_pkg::KS_KEYED && reg_addr == `PCM_ADDR_PLL_CTL)
        pll_pending <= reg_wdata & `PCM_MASK_PLL_CTL;
      if (pow0_ks == pcm_pkg::KS_KEYED && reg_addr == `PCM_ADDR_POW_CTL0)
        pow0_pending <= reg_wdata & `PCM_MASK_POW_CTL0;
      if (pow1_ks == pcm_pkg::KS_KEYED && reg_addr == `PCM_ADDR_POW_CTL1)
        pow1_pending <= reg_wdata & `PCM_MASK_POW_CTL1;
    end
  end

  // clocking mode register, internal oscillator and pll by default
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pll_control_reg <= `PCM_RST_PLL_CTL;
    else if (pll_commit)
      pll_control_reg <= pll_pending;
  end

  // divider and mode register; hardware clears the mode on wake
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      core_power_control_reg <= `PCM_RST_POW_CTL0;
    else if (pow0_commit)
      core_power_control_reg <= pow0_pending;
    else if (wake_done)
      core_power_control_reg[`PCM_MODE_MSB:`PCM_MODE_LSB] <= pcm_pkg::MODE_ACTIVE;
  end

  // serial peripheral clock register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      serial_clock_control_reg <= `PCM_RST_POW_CTL1;
    else if (pow1_commit)
      serial_clock_control_reg <= pow1_pending;
  end

  // field outputs
  assign core_clock_divider = core_power_control_reg[`PCM_DIV_MSB:`PCM_DIV_LSB];
  assign serial_clock_config = serial_clock_control_reg[`PCM_POW1_MSB:0];
  assign pll_ref_internal = pll_control_reg[`PCM_REFSEL_BIT];
  assign use_ext = pll_control_reg[`PCM_CLKMODE_MSB:`PCM_CLKMODE_LSB] == `PCM_CLKMODE_EXT;
  assign pll_mult_ratio = `PCM_PLL_MULT;
  assign req_mode = pcm_pkg::pcm_mode_t'(core_power_control_reg[`PCM_MODE_MSB:`PCM_MODE_LSB]);

  // wake sources: irq0-3 always, other interrupts only in pause and nap
  assign wake_event = (|ext_wake_irq) ||
                      (periph_irq && (low_mode == pcm_pkg::MODE_PAUSE || low_mode == pcm_pkg::MODE_NAP));
  assign wake_done = (fsm == pcm_pkg::ST_WAKE) && (wake_cnt == '0) && (use_ext || pll_locked);

  // restore time per mode, fast figure only at divider zero
  always_comb
  begin
    wake_load = CYC_SLOW;
    unique case (low_mode)
      pcm_pkg::MODE_PAUSE: wake_load = (core_clock_divider == 3'h0) ? CYC_PAUSE_FAST : CYC_SLOW;
      pcm_pkg::MODE_NAP: wake_load = (core_clock_divider == 3'h0) ? CYC_NAP_FAST : CYC_SLOW;
      pcm_pkg::MODE_SLEEP: wake_load = CYC_SLEEP;
      pcm_pkg::MODE_STOP: wake_load = CYC_STOP;
      default: wake_load = CYC_SLOW;
    endcase
  end

  // next sequencer state; reserved mode codes keep the part active
  always_comb
  begin
    next_fsm = fsm;
    unique case (fsm)
      pcm_pkg::ST_ACTIVE:
        if (req_mode inside {pcm_pkg::MODE_PAUSE, pcm_pkg::MODE_NAP, pcm_pkg::MODE_SLEEP, pcm_pkg::MODE_STOP})
          next_fsm = pcm_pkg::ST_LOW;
      pcm_pkg::ST_LOW:
        if (wake_event)
          next_fsm = pcm_pkg::ST_WAKE;
      pcm_pkg::ST_WAKE:
        if (wake_done)
          next_fsm = pcm_pkg::ST_ACTIVE;
      default: next_fsm = pcm_pkg::ST_ACTIVE;
    endcase
  end

  // sequencer state, captured mode and wake counter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fsm <= pcm_pkg::ST_ACTIVE;
      low_mode <= pcm_pkg::MODE_ACTIVE;
      wake_cnt <= '0;
    end
    else
    begin
      fsm <= next_fsm;
      if (fsm == pcm_pkg::ST_ACTIVE && next_fsm == pcm_pkg::ST_LOW)
        low_mode <= req_mode;
      else if (wake_done)
        low_mode <= pcm_pkg::MODE_ACTIVE;
      if (fsm == pcm_pkg::ST_LOW && wake_event)
        wake_cnt <= wake_load;
      else if (fsm == pcm_pkg::ST_WAKE && wake_cnt != '0)
        wake_cnt <= wake_cnt - CNT_ONE;
    end
  end

  // domain gates; during wake all domains are back, core waits
  assign periph_clk_run = !(fsm == pcm_pkg::ST_LOW && low_mode >= pcm_pkg::MODE_NAP);
  assign pll_power_en = !(fsm == pcm_pkg::ST_LOW && low_mode >= pcm_pkg::MODE_SLEEP);
  assign xtal_timer_en = !(fsm == pcm_pkg::ST_LOW && low_mode == pcm_pkg::MODE_STOP);
  // lock loss halts the core at once when the pll feeds it
  assign core_clk_run = (fsm == pcm_pkg::ST_ACTIVE) && (use_ext || pll_locked);

  // core clock divider and external source
  pcm_core_clock_gen #(
    .CNT_W(8)
  ) u_clock_gen (
    .clk(clk),
    .rst_n(rst_n),
    .core_clock_divider(core_clock_divider),
    .use_ext(use_ext),
    .run(core_clk_run),
    .external_clock_input(external_clock_input),
    .core_clock_tick(core_clock_tick)
  );

  // lock history for the unlock event
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pll_locked_q <= 1'b0;
    else
      pll_locked_q <= pll_locked;
  end

  assign unlock_event = pll_locked_q && !pll_locked && pll_power_en && !use_ext;
  assign irq_set = {wake_done, unlock_event};

  // sticky events, write one to clear, a new event wins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_status <= 2'h0;
    else if (reg_wr && reg_addr == `PCM_ADDR_IRQ_STAT)
      irq_status <= (irq_status & ~reg_wdata[1:0]) | irq_set;
    else
      irq_status <= irq_status | irq_set;
  end

  // interrupt mask
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_mask <= 2'h0;
    else if (reg_wr && reg_addr == `PCM_ADDR_IRQ_MASK)
      irq_mask <= reg_wdata[1:0];
  end

  // unlock interrupt is only presented once lock is back
  assign irq = |(irq_status & irq_mask & {1'b1, pll_locked});

  // watchdog reset cause, caught on the first edge after release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cause_taken <= 1'b0;
      reset_cause_status <= 1'b0;
    end
    else if (!cause_taken)
    begin
      cause_taken <= 1'b1;
      reset_cause_status <= wdt_reset_cause;
    end
    else if (reg_wr && reg_addr == `PCM_ADDR_RST_CAUSE && reg_wdata[0])
      reset_cause_status <= 1'b0;
  end

  // read data, one cycle after the strobe; keys and holes read zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        `PCM_ADDR_PLL_CTL: reg_rdata <= pll_control_reg;
        `PCM_ADDR_POW_CTL0: reg_rdata <= core_power_control_reg;
        `PCM_ADDR_POW_CTL1: reg_rdata <= serial_clock_control_reg;
        `PCM_ADDR_IRQ_STAT: reg_rdata <= {14'h0000, irq_status};
        `PCM_ADDR_IRQ_MASK: reg_rdata <= {14'h0000, irq_mask};
        `PCM_ADDR_RST_CAUSE: reg_rdata <= {15'h0000, reset_cause_status};
        `PCM_ADDR_STATUS: reg_rdata <= {13'h0000, fsm != pcm_pkg::ST_ACTIVE, core_clk_run, pll_locked};
        default: reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_divider_change_key: assert property (!$stable(core_clock_divider) |-> $past(pow0_commit))
    else $error("divider changed without key sequence");
  chk_pll_ctl_commit: assert property (pll_commit |=> pll_control_reg == $past(pll_pending))
    else $error("pll control did not take held value");
  chk_pll_ctl_guard: assert property (!$stable(pll_control_reg) |-> $past(pll_commit))
    else $error("pll control changed outside sequence");
  chk_unlock_halts_core: assert property (!use_ext && !pll_locked |-> !core_clk_run)
    else $error("core runs without pll lock");
  chk_unlock_sets_flag: assert property ($fell(pll_locked) && pll_power_en && !use_ext |=> irq_status[0])
    else $error("unlock event not recorded");
  chk_pause_gates: assert property (fsm == pcm_pkg::ST_LOW && low_mode == pcm_pkg::MODE_PAUSE
                                    |-> !core_clk_run && periph_clk_run && pll_power_en)
    else $error("pause gating wrong");
  chk_nap_gates: assert property (fsm == pcm_pkg::ST_LOW && low_mode == pcm_pkg::MODE_NAP
                                  |-> !periph_clk_run && pll_power_en && xtal_timer_en)
    else $error("nap gating wrong");
  chk_sleep_stop_gates: assert property (fsm == pcm_pkg::ST_LOW && low_mode >= pcm_pkg::MODE_SLEEP
                                         |-> !pll_power_en && (xtal_timer_en == (low_mode == pcm_pkg::MODE_SLEEP)))
    else $error("sleep or stop gating wrong");
  chk_pause_wake_time: assert property ($rose(fsm == pcm_pkg::ST_WAKE) && low_mode == pcm_pkg::MODE_PAUSE
                                        && core_clock_divider == 3'h0 && pll_locked
                                        |-> !core_clk_run [*8] ##[15:20] core_clk_run)
    else $error("pause wake timing wrong");
  chk_core_only_active: assert property (core_clk_run |-> fsm == pcm_pkg::ST_ACTIVE && periph_clk_run)
    else $error("core runs before domains restored");
  chk_wake_clears_mode: assert property (wake_done && !pow0_commit |=> req_mode == pcm_pkg::MODE_ACTIVE
                                         && fsm == pcm_pkg::ST_ACTIVE)
    else $error("wake left mode field set");

  cov_pll_commit: cover property (pll_commit);
  cov_pow0_commit: cover property (pow0_commit);
  cov_enter_sleep: cover property (fsm == pcm_pkg::ST_LOW && low_mode == pcm_pkg::MODE_SLEEP);
  cov_wake_done: cover property (wake_done);
endmodule : pcm_top
`default_nettype wire

// ---- test_pcm_top.sv ----
`include "pcm_params.svh"
`timescale 1ns/1ps
`default_nettype none
module test_pcm_top;
  // clock, reset and register port
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  // pll, pins and wake sources
  logic pll_locked = 1'b1;
  logic external_clock_input = 1'b0;
  logic [3:0] ext_wake_irq = 4'h0;
  logic periph_irq = 1'b0;
  logic wdt_reset_cause = 1'b1;
  // observed outputs
  logic pll_power_en, pll_ref_internal, core_clock_tick, core_clk_run, periph_clk_run, xtal_timer_en, irq;
  logic [10:0] pll_mult_ratio;
  logic [2:0] core_clock_divider;
  logic [8:0] serial_clock_config;
  // bookkeeping
  int n_mismatch = 0;
  int n_tests = 0;
  logic [15:0] rv;
  logic [2:0] ext_cnt = 3'h0;

  // free running system clock
  always #5 clk = ~clk;

  // external clock pin: one rising edge every eight cycles
  always @(posedge clk)
  begin
    ext_cnt <= ext_cnt + 3'h1;
    external_clock_input <= ext_cnt[2];
  end

  // wake counts shortened for sleep and stop
  pcm_top #(.SLEEP_WAKE_CYCLES(50), .STOP_WAKE_CYCLES(60)) i_pcm_top (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pll_locked(pll_locked), .pll_power_en(pll_power_en),
    .pll_ref_internal(pll_ref_internal), .pll_mult_ratio(pll_mult_ratio),
    .external_clock_input(external_clock_input), .core_clock_tick(core_clock_tick),
    .core_clk_run(core_clk_run), .periph_clk_run(periph_clk_run), .xtal_timer_en(xtal_timer_en),
    .core_clock_divider(core_clock_divider), .serial_clock_config(serial_clock_config),
    .ext_wake_irq(ext_wake_irq), .periph_irq(periph_irq), .wdt_reset_cause(wdt_reset_cause), .irq(irq));

  // verdict and end of run
  task close_out;
    if (n_mismatch == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // single comparison point
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one-cycle write strobe, then one idle cycle
  task wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data is taken in the cycle after the strobe
  task rd(input logic [31:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rv = reg_rdata;
  endtask : rd

  // protected updates through their key writes
  task pll_set(input logic [15:0] v);
    wr(`PCM_ADDR_PLL_KEY1, 16'h00AA);
    wr(`PCM_ADDR_PLL_CTL, v);
    wr(`PCM_ADDR_PLL_KEY2, 16'h0055);
  endtask : pll_set

  task pow0_set(input logic [15:0] v);
    wr(`PCM_ADDR_POW_KEY1, 16'h0001);
    wr(`PCM_ADDR_POW_CTL0, v);
    wr(`PCM_ADDR_POW_KEY2, 16'h00F4);
  endtask : pow0_set

  // let the sequencer take the committed mode
  task settle;
    @(posedge clk);
    @(negedge clk);
  endtask : settle

  // bounded wait for the core clock to come back
  task wait_core(output int cnt);
    for (cnt = 0; cnt < 2000 && core_clk_run !== 1'b1; cnt++)
      @(negedge clk);
    if (core_clk_run !== 1'b1)
    begin
      n_mismatch++;
      close_out;
    end
  endtask : wait_core

  // reset values, identity of the multiplier, reset cause, unmapped read
  task t_reset;
    rd(`PCM_ADDR_PLL_CTL);
    chk(rv, 16'h0021);
    rd(`PCM_ADDR_POW_CTL0);
    chk(rv, 16'h0003);
    rd(`PCM_ADDR_POW_CTL1);
    chk(rv, 16'h0004);
    chk({13'h0, core_clock_divider}, 16'h0003);
    chk({5'h0, pll_mult_ratio}, 16'h04FB);
    chk({15'h0, pll_ref_internal}, 16'h0001);
    rd(`PCM_ADDR_RST_CAUSE);
    chk(rv, 16'h0001);
    rd(32'h0000_0000);
    chk(rv, 16'h0000);
  endtask : t_reset

  // refused and accepted key sequences
  task t_keys;
    wr(`PCM_ADDR_PLL_CTL, 16'h0000);
    rd(`PCM_ADDR_PLL_CTL);
    chk(rv, 16'h0021);
    wr(`PCM_ADDR_PLL_KEY1, 16'h00AA);
    wr(`PCM_ADDR_PLL_CTL, 16'h0000);
    wr(`PCM_ADDR_PLL_KEY2, 16'h0056);
    rd(`PCM_ADDR_PLL_CTL);
    chk(rv, 16'h0021);
    wr(`PCM_ADDR_PLL_KEY1, 16'h00AA);
    wr(`PCM_ADDR_IRQ_MASK, 16'h0000);
    wr(`PCM_ADDR_PLL_CTL, 16'h0000);
    wr(`PCM_ADDR_PLL_KEY2, 16'h0055);
    rd(`PCM_ADDR_PLL_CTL);
    chk(rv, 16'h0021);
    pll_set(16'hFFFF);
    rd(`PCM_ADDR_PLL_CTL);
    chk(rv, 16'h0023);
    pll_set(16'h0001);
    @(negedge clk);
    chk({15'h0, pll_ref_internal}, 16'h0000);
    wr(`PCM_ADDR_POW_KEY3, 16'h0076);
    wr(`PCM_ADDR_POW_CTL1, 16'h01FF);
    wr(`PCM_ADDR_POW_KEY4, 16'h00B1);
    @(negedge clk);
    chk({7'h0, serial_clock_config}, 16'h01FF);
  endtask : t_keys

  // core tick rate for dividers zero to three, then from the external pin
  task t_div;
    int c;
    for (int dv = 0; dv < 4; dv++)
    begin
      pow0_set(16'(dv));
      @(negedge clk);
      chk({13'h0, core_clock_divider}, 16'(dv));
      c = 0;
      repeat (32)
      begin
        @(negedge clk);
        c += int'(core_clock_tick === 1'b1);
      end
      chk(16'(c), 16'(32 >> dv));
    end
    pll_set(16'h0003);
    @(negedge clk);
    c = 0;
    repeat (32)
    begin
      @(negedge clk);
      c += int'(core_clock_tick === 1'b1);
    end
    chk(16'(c), 16'h0004);
    pll_set(16'h0021);
  endtask : t_div

  // each low-power mode: gates, wake sources, wake time, status interrupt
  task t_modes;
    int cnt;
    int lo[4] = '{23, 29, 50, 60};
    wr(`PCM_ADDR_IRQ_MASK, 16'h0003);
    pow0_set(16'h0000);
    for (int m = 1; m < 5; m++)
    begin
      pow0_set(16'(m << 4));
      settle;
      chk({12'h0, core_clk_run, periph_clk_run, pll_power_en, xtal_timer_en},
          {12'h0, 1'b0, m == 1, m < 3, m < 4});
      rd(`PCM_ADDR_STATUS);
      chk(rv, 16'h0005);
      if (m > 2)
      begin
        periph_irq <= 1'b1;
        repeat (10) @(posedge clk);
        periph_irq <= 1'b0;
        @(negedge clk);
        chk({15'h0, core_clk_run}, 16'h0000);
      end
      @(posedge clk);
      ext_wake_irq <= 4'h1 << (m - 1);
      wait_core(cnt);
      chk({13'h0, periph_clk_run, pll_power_en, xtal_timer_en}, 16'h0007);
      chk(16'(cnt >= lo[m-1]), 16'h0001);
      @(posedge clk);
      ext_wake_irq <= 4'h0;
      rd(`PCM_ADDR_POW_CTL0);
      chk(rv, 16'h0000);
      rd(`PCM_ADDR_IRQ_STAT);
      chk(rv, 16'h0002);
      chk({15'h0, irq}, 16'h0001);
      wr(`PCM_ADDR_IRQ_STAT, 16'h0002);
      @(negedge clk);
      chk({15'h0, irq}, 16'h0000);
    end
    pow0_set(16'h0050);
    settle;
    chk({15'h0, core_clk_run}, 16'h0001);
  endtask : t_modes

  // lock loss halts the core, interrupt held back until relock
  task t_lock;
    wr(`PCM_ADDR_IRQ_MASK, 16'h0001);
    pll_locked <= 1'b0;
    repeat (3) @(negedge clk);
    chk({14'h0, core_clk_run, irq}, 16'h0000);
    rd(`PCM_ADDR_IRQ_STAT);
    chk(rv, 16'h0001);
    @(posedge clk);
    pll_locked <= 1'b1;
    settle;
    chk({14'h0, core_clk_run, irq}, 16'h0003);
    wr(`PCM_ADDR_IRQ_MASK, 16'h0000);
    @(negedge clk);
    chk({15'h0, irq}, 16'h0000);
    wr(`PCM_ADDR_IRQ_STAT, 16'h0001);
    rd(`PCM_ADDR_IRQ_STAT);
    chk(rv, 16'h0000);
  endtask : t_lock

  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wdt_reset_cause <= 1'b0;
    t_reset;
    t_keys;
    t_div;
    t_modes;
    t_lock;
    close_out;
  end
endmodule : test_pcm_top
`default_nettype wire
